// [design/vlt_pkg.sv]
// Package for the video line timing generator: register map, control fields, reset values, state codes.
// Assumes one 32-bit AHB-Lite slave port; each register is one word at byte address 4 x index.
package vlt_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int TW = 12;
  localparam int IW = 10;
  localparam int DLY_TAPS = 8;
  localparam int DLY_W = 4;

  // ----------------------------------------
  // Register indices (byte address = 4 x index)
  // ----------------------------------------
  localparam logic [IW-1:0] IDX_HALF_SYNC = 10'h021;
  localparam logic [IW-1:0] IDX_BACK_PORCH = 10'h022;
  localparam logic [IW-1:0] IDX_DISPLAY = 10'h023;
  localparam logic [IW-1:0] IDX_VSYNC = 10'h026;
  localparam logic [IW-1:0] IDX_PRE_EQ = 10'h027;
  localparam logic [IW-1:0] IDX_POST_EQ = 10'h028;
  localparam logic [IW-1:0] IDX_VBLANK = 10'h029;
  localparam logic [IW-1:0] IDX_VDISPLAY = 10'h02A;
  localparam logic [IW-1:0] IDX_LINE_TIME = 10'h02B;
  localparam logic [IW-1:0] IDX_CTRL = 10'h060;
  localparam logic [IW-1:0] IDX_STATUS = 10'h061;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTRL_EN = 0;
  localparam int CTRL_INTERLACE = 1;
  localparam int CTRL_STANDARD = 2;
  localparam int CTRL_SLAVE = 3;
  localparam int CTRL_FORCE_BLANK = 10;
  localparam int CTRL_BLANK_OFF = 11;
  localparam int CTRL_DLY_LO = 15;
  localparam int CTRL_DLY_HI = 17;
  localparam int CTRL_W = 24;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [TW-1:0] RST_SEG = 12'h002;
  localparam logic [TW-1:0] RST_LINE_TIME = 12'h010;
  localparam logic [TW-1:0] RST_VDISPLAY = 12'h004;
  localparam logic [CTRL_W-1:0] RST_CTRL = 24'h000000;
  localparam logic [TW-1:0] ONE = 12'h001;

  // ----------------------------------------
  // State codes, Gray along the usual path except the wrap from 3'b110 back to 3'b000
  // ----------------------------------------
  typedef enum logic [2:0] {
    L_SYNC1 = 3'b000, L_SYNC2 = 3'b001, L_BPORCH = 3'b011, L_DISP = 3'b010, L_FPORCH = 3'b110
  } vlt_line_t;
  typedef enum logic [2:0] {
    V_PRE = 3'b000, V_SYNC = 3'b001, V_POST = 3'b011, V_BLANK = 3'b010, V_DISP = 3'b110
  } vlt_frame_t;

endpackage

// [design/vlt_down_counter.sv]
// Loadable down-counter used for segment and half-line durations.
// Assumes load and ce come from the same clock domain; counter rests at zero.
`timescale 1ns/1ps
module vlt_down_counter #(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Control
  input wire logic load,
  input wire logic [W-1:0] value,
  // Status
  output logic zero
);

  logic [W-1:0] cnt_reg;

  // Load wins over counting; stops at zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_reg <= '0;
    else if (ce)
    begin
      if (load)
        cnt_reg <= value;
      else if (cnt_reg != '0)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign zero = (cnt_reg == '0);

  // A load is seen in the counter one serial clock later
  load_value_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ19
    (ce && load) |=> (cnt_reg == $past(value)))
    else $error("counter did not take loaded value");

endmodule

// [design/vlt_delay_line.sv]
// Programmable 1..8 stage delay for the sync and blank outputs.
// Assumes sel is quasi-static; changing it mid-frame may glitch the outputs.
`timescale 1ns/1ps
module vlt_delay_line
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Data
  input wire logic [vlt_pkg::DLY_W-1:0] din,
  input wire logic [2:0] sel,
  output logic [vlt_pkg::DLY_W-1:0] dout
);
  import vlt_pkg::*;

  logic [DLY_W-1:0] sh_reg [DLY_TAPS-1];

  // Tap chain; sel 0 gives only the output register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < DLY_TAPS - 1; i++)
        sh_reg[i] <= '1;
      dout <= '1;
    end
    else if (ce)
    begin
      sh_reg[0] <= din;
      for (int i = 1; i < DLY_TAPS - 1; i++)
        sh_reg[i] <= sh_reg[i-1];
      dout <= (sel == 3'h0) ? din : sh_reg[sel - 3'h1]; // see RQ17
    end
  end

endmodule

// [design/vlt_timing_top.sv]
// Video line timing generator: line and frame state machines, sync/blank, memory pacing, AHB-Lite registers.
// Assumes inputs synchronous to hclk; one hclk cycle with ce high is one serial clock (one screen unit).
//
// Behaviour
// RQ1: drive composite sync and blank to converters
// RQ2: time bus request and transfer strobe
// RQ3: gate pixel shift clock to display only
// RQ4: flyback flag throughout vertical flyback
// RQ5: blank during line and frame flyback
// RQ6: control selects interlace and sync standard
// RQ7: master drives sync, slave follows inputs
// RQ8: horizontal timing in four-pixel units
// RQ9: frame periods counted in half lines
// RQ10: line is display, porches, sync; total programmed
// RQ11: only display segment unblanked
// RQ12: line sync is two equal half-syncs
// RQ13: front porch ends at line period expiry
// RQ14: advance state when duration elapses
// RQ15: outputs follow state on entry
// RQ16: one screen unit per serial clock
// RQ17: sync and blank delayed 0 to 7
// RQ18: enable starts at frame sync
// RQ19: down-counter per segment, free line counter
// RQ20: disabled holds blank and stops shift clock
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module vlt_timing_top
(
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Sync pins
  input wire logic hsync_n_i,
  output logic hsync_n_o,
  output logic hsync_n_oe,
  input wire logic vsync_n_i,
  output logic vsync_n_o,
  output logic vsync_n_oe,
  // Converter and memory side
  output logic composite_sync_n,
  output logic composite_blank,
  output logic frame_flyback_flag,
  output logic memory_bus_request,
  output logic vram_transfer_strobe,
  output logic pixel_shift_clock_n
);
  import vlt_pkg::*;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [TW-1:0] half_sync_reg, back_porch_reg, display_reg, line_time_reg;
  logic [TW-1:0] vsync_reg, pre_eq_reg, post_eq_reg, vblank_reg, vdisplay_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic wr_pend_reg;
  logic [IW-1:0] wr_idx_reg;
  logic [31:0] rd_next;
  logic [31:0] status;
  logic addr_ok;
  logic [IW-1:0] a_idx;

  vlt_line_t line_reg;
  vlt_frame_t frame_reg;
  logic en_d_reg, field_reg;

  // Bus stalls while frozen, so no write or read is lost
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign a_idx = haddr[IW+1:2];
  assign addr_ok = hsel && hready && htrans[1];

  // Write data phase follows a one-cycle address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= '0;
    end
    else if (ce && hready)
    begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_idx_reg <= a_idx;
    end
  end

  // Timing registers only take writes while the engine is stopped, so a line is never torn
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      half_sync_reg <= RST_SEG;
      back_porch_reg <= RST_SEG;
      display_reg <= RST_SEG;
      vsync_reg <= RST_SEG;
      pre_eq_reg <= RST_SEG;
      post_eq_reg <= RST_SEG;
      vblank_reg <= RST_SEG;
      vdisplay_reg <= RST_VDISPLAY;
      line_time_reg <= RST_LINE_TIME;
    end
    else if (ce && wr_pend_reg && !ctrl_reg[CTRL_EN])
    begin
      case (wr_idx_reg)
        IDX_HALF_SYNC: half_sync_reg <= hwdata[TW-1:0];
        IDX_BACK_PORCH: back_porch_reg <= hwdata[TW-1:0];
        IDX_DISPLAY: display_reg <= hwdata[TW-1:0];
        IDX_VSYNC: vsync_reg <= hwdata[TW-1:0];
        IDX_PRE_EQ: pre_eq_reg <= hwdata[TW-1:0];
        IDX_POST_EQ: post_eq_reg <= hwdata[TW-1:0];
        IDX_VBLANK: vblank_reg <= hwdata[TW-1:0];
        IDX_VDISPLAY: vdisplay_reg <= hwdata[TW-1:0];
        IDX_LINE_TIME: line_time_reg <= hwdata[TW-1:0];
        default: ;
      endcase
    end
  end

  // Control register is writable at any time
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_reg <= RST_CTRL;
    else if (ce && wr_pend_reg && wr_idx_reg == IDX_CTRL)
      ctrl_reg <= hwdata[CTRL_W-1:0]; // see RQ6
  end

  assign status = {24'h000000, field_reg, frame_reg, line_reg, en_d_reg};

  // Read data decoded in the address phase so it stands in the data phase
  always_comb
  begin
    rd_next = 32'h00000000;
    case (a_idx)
      IDX_HALF_SYNC: rd_next[TW-1:0] = half_sync_reg;
      IDX_BACK_PORCH: rd_next[TW-1:0] = back_porch_reg;
      IDX_DISPLAY: rd_next[TW-1:0] = display_reg;
      IDX_VSYNC: rd_next[TW-1:0] = vsync_reg;
      IDX_PRE_EQ: rd_next[TW-1:0] = pre_eq_reg;
      IDX_POST_EQ: rd_next[TW-1:0] = post_eq_reg;
      IDX_VBLANK: rd_next[TW-1:0] = vblank_reg;
      IDX_VDISPLAY: rd_next[TW-1:0] = vdisplay_reg;
      IDX_LINE_TIME: rd_next[TW-1:0] = line_time_reg;
      IDX_CTRL: rd_next[CTRL_W-1:0] = ctrl_reg;
      IDX_STATUS: rd_next = status;
      default: rd_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (ce && addr_ok && !hwrite)
      hrdata <= rd_next;
  end

  // ----------------------------------------
  // Line state machine
  // ----------------------------------------
  logic en, slave, hs_prev_reg, vs_prev_reg, hs_fall, vs_fall;
  logic en_start, frame_start, line_end, line_start, half_tick;
  logic [TW-1:0] line_cnt_reg;
  logic seg_load, seg_zero, v_load, v_zero;
  logic [TW-1:0] seg_val, v_val, lt_half;

  assign en = ctrl_reg[CTRL_EN];
  assign slave = ctrl_reg[CTRL_SLAVE];
  assign en_start = en && !en_d_reg;
  assign hs_fall = slave && hs_prev_reg && !hsync_n_i; // see RQ7
  assign vs_fall = slave && vs_prev_reg && !vsync_n_i;
  assign frame_start = en_start || vs_fall; // see RQ18
  assign line_end = !slave && (line_cnt_reg == line_time_reg - ONE); // see RQ13
  assign line_start = frame_start || hs_fall || (en && line_end);
  assign lt_half = {1'b0, line_time_reg[TW-1:1]} - ONE;
  assign half_tick = line_start || (line_cnt_reg == lt_half); // see RQ9

  // Enable edge and external sync history
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_d_reg <= 1'b0;
      hs_prev_reg <= 1'b1;
      vs_prev_reg <= 1'b1;
    end
    else if (ce)
    begin
      en_d_reg <= en;
      hs_prev_reg <= hsync_n_i;
      vs_prev_reg <= vsync_n_i;
    end
  end

  // Line period counts one screen unit per serial clock, free of the segment counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      line_cnt_reg <= '0;
    else if (ce)
      line_cnt_reg <= (line_start || !en) ? '0 : line_cnt_reg + ONE; // see RQ8, RQ16, RQ19
  end

  // Segment durations: two half-syncs, back porch, display; rest is front porch
  always_comb
  begin
    seg_load = 1'b0;
    seg_val = '0;
    if (line_start)
    begin
      seg_load = 1'b1;
      seg_val = half_sync_reg - ONE;
    end
    else if (seg_zero)
    begin
      seg_load = 1'b1;
      case (line_reg)
        L_SYNC1: seg_val = half_sync_reg - ONE; // see RQ12
        L_SYNC2: seg_val = back_porch_reg - ONE;
        L_BPORCH: seg_val = display_reg - ONE;
        default: seg_load = 1'b0;
      endcase
    end
  end

  vlt_down_counter #(.W(TW)) u_seg_cnt (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .load(seg_load),
    .value(seg_val),
    .zero(seg_zero)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      line_reg <= L_FPORCH;
    else if (ce)
    begin
      if (!en)
        line_reg <= L_FPORCH;
      else if (line_start)
        line_reg <= L_SYNC1;
      else if (seg_zero)
      begin
        case (line_reg) // see RQ10, RQ14
          L_SYNC1: line_reg <= L_SYNC2;
          L_SYNC2: line_reg <= L_BPORCH;
          L_BPORCH: line_reg <= L_DISP;
          L_DISP: line_reg <= L_FPORCH;
          L_FPORCH: line_reg <= L_FPORCH;
          default: line_reg <= L_FPORCH;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Frame state machine, in half lines
  // ----------------------------------------
  always_comb
  begin
    v_load = 1'b0;
    v_val = '0;
    if (frame_start)
    begin
      v_load = 1'b1;
      v_val = vsync_reg - ONE;
    end
    else if (en && half_tick && v_zero)
    begin
      v_load = 1'b1;
      case (frame_reg)
        V_PRE: v_val = vsync_reg - ONE;
        V_SYNC: v_val = post_eq_reg - ONE;
        V_POST: v_val = field_reg ? vblank_reg : vblank_reg - ONE; // odd field adds the half line
        V_BLANK: v_val = vdisplay_reg - ONE;
        default: v_val = pre_eq_reg - ONE;
      endcase
    end
    else if (en && half_tick)
      v_load = 1'b0;
  end

  vlt_down_counter #(.W(TW)) u_half_cnt (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce && (v_load || half_tick)),
    .load(v_load),
    .value(v_val),
    .zero(v_zero)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      frame_reg <= V_SYNC;
      field_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (frame_start)
        frame_reg <= V_SYNC;
      else if (en && half_tick && v_zero)
      begin
        case (frame_reg)
          V_PRE: frame_reg <= V_SYNC;
          V_SYNC: frame_reg <= V_POST;
          V_POST: frame_reg <= V_BLANK;
          V_BLANK: frame_reg <= V_DISP;
          V_DISP: frame_reg <= V_PRE;
          default: frame_reg <= V_SYNC;
        endcase
        if (frame_reg == V_DISP)
          field_reg <= ctrl_reg[CTRL_INTERLACE] && !field_reg; // see RQ6
      end
    end
  end

  // ----------------------------------------
  // Sync and blank generation
  // ----------------------------------------
  logic flyback, hsync_act, vsync_act, csync_act, blank_raw;
  logic [DLY_W-1:0] dly_out;

  assign flyback = (frame_reg != V_DISP);
  assign hsync_act = en && (line_reg == L_SYNC1 || line_reg == L_SYNC2); // see RQ15
  assign vsync_act = en && (frame_reg == V_SYNC);
  // Standard bit 1 holds sync low through vsync; 0 serrates it with line sync
  assign csync_act = vsync_act ? (ctrl_reg[CTRL_STANDARD] || !hsync_act) : hsync_act;
  assign blank_raw = !en || ctrl_reg[CTRL_FORCE_BLANK] ||
    (!ctrl_reg[CTRL_BLANK_OFF] && (flyback || line_reg != L_DISP)); // see RQ5, RQ11, RQ20

  vlt_delay_line u_dly (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .din({!csync_act, !hsync_act, !vsync_act, blank_raw}),
    .sel(ctrl_reg[CTRL_DLY_HI:CTRL_DLY_LO]),
    .dout(dly_out)
  );

  assign composite_sync_n = dly_out[3]; // see RQ1
  assign hsync_n_o = dly_out[2];
  assign vsync_n_o = dly_out[1];
  assign composite_blank = dly_out[0];
  assign hsync_n_oe = !slave; // see RQ7
  assign vsync_n_oe = !slave;

  // ----------------------------------------
  // Memory pacing and pixel shift gate
  // ----------------------------------------
  // Request opens at back porch of a displayed line; transfer marks display start
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      memory_bus_request <= 1'b0;
      vram_transfer_strobe <= 1'b0;
      pixel_shift_clock_n <= 1'b1;
      frame_flyback_flag <= 1'b0;
    end
    else if (ce)
    begin
      memory_bus_request <= en && !flyback && (line_reg == L_BPORCH); // see RQ2
      vram_transfer_strobe <= en && !flyback && (line_reg == L_BPORCH) && seg_zero;
      pixel_shift_clock_n <= !(en && !flyback && line_reg == L_DISP); // see RQ3
      frame_flyback_flag <= en && flyback; // see RQ4
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  blank_when_off_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ20
    !en |-> blank_raw)
    else $error("blank not held while disabled");

  shift_stop_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ3
    (ce && line_reg != L_DISP) |=> pixel_shift_clock_n)
    else $error("shift clock ran outside display");

  flyback_flag_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ4
    (ce && en && frame_reg == V_SYNC) |=> frame_flyback_flag)
    else $error("flyback flag missing in vsync");

  sync_halves_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ12
    (ce && en && line_reg == L_SYNC1 && seg_zero && !line_start) |=> line_reg == L_SYNC2)
    else $error("second half-sync not entered");

  line_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ13
    (ce && en && line_end) |=> (line_reg == L_SYNC1 && line_cnt_reg == '0))
    else $error("line did not restart at period end");

  display_only_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ11
    (line_reg != L_DISP && !ctrl_reg[CTRL_BLANK_OFF]) |-> blank_raw)
    else $error("unblanked outside display");

  frame_begin_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ18
    (ce && en_start) |=> (frame_reg == V_SYNC && line_reg == L_SYNC1))
    else $error("enable did not start at frame sync");

  pin_dir_a: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ7
    slave |-> (!hsync_n_oe && !vsync_n_oe))
    else $error("sync pins driven in slave mode");

endmodule

// [verification/vlt_sync_source.sv]
// Partner model: external line and frame sync source for slave-mode runs.
// Assumes the bench resolves the shared pins; the pins idle high (pull-up) while disabled.
`timescale 1ns/1ps
module vlt_sync_source #(
  parameter int LINE = 120,
  parameter int LINES = 17,
  parameter int PULSE = 4
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic en,
  // Sync outputs, active low
  output logic hsync_n,
  output logic vsync_n
);
  int pix;
  int line;

  // --------------------------------
  // Line and frame counters
  // --------------------------------
  // Restart from zero whenever disabled, so the first pulse is a clean fall
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pix <= 0;
      line <= 0;
    end
    else if (!en)
    begin
      pix <= 0;
      line <= 0;
    end
    else
    begin
      pix <= (pix == LINE - 1) ? 0 : pix + 1;
      if (pix == LINE - 1)
        line <= (line == LINES - 1) ? 0 : line + 1;
    end
  end

  // Frame pulse shares the first line pulse, as a genlock source would
  assign hsync_n = !(en && pix < PULSE);
  assign vsync_n = !(en && line == 0 && pix < PULSE);
endmodule

// [verification/test_vlt_timing_top.sv]
// Self-checking bench for the video line timing generator, driven over AHB-Lite.
// Assumes zero-wait slave; slave-mode sync comes from the partner model.
`timescale 1ns/1ps
module test_vlt_timing_top;
  import vlt_pkg::*;
  localparam logic [IW-1:0] TIDX [9] = '{IDX_HALF_SYNC, IDX_BACK_PORCH, IDX_DISPLAY, IDX_VSYNC,
    IDX_PRE_EQ, IDX_POST_EQ, IDX_VBLANK, IDX_VDISPLAY, IDX_LINE_TIME};
  localparam logic [TW-1:0] TVAL [9] = '{12'h003, 12'h014, 12'h028, 12'h003, 12'h003, 12'h003,
    12'h005, 12'h016, 12'h064};
  logic hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp, sl_en = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic hsync_n_o, hsync_n_oe, vsync_n_o, vsync_n_oe, src_h, src_v, hpin, vpin;
  logic composite_sync_n, composite_blank, frame_flyback_flag, memory_bus_request;
  logic vram_transfer_strobe, pixel_shift_clock_n;
  int fail_count = 0, cmp_count = 0, cyc = 0, n, off0;

  // --------------------------------
  // Clock, pins, instances
  // --------------------------------
  initial forever #2 hclk = ~hclk;
  assign hready = hreadyout;
  // Shared sync pins: design when its output enable is high (master), else partner, else pull-up
  assign hpin = hsync_n_oe ? hsync_n_o : (sl_en ? src_h : 1'b1);
  assign vpin = vsync_n_oe ? vsync_n_o : (sl_en ? src_v : 1'b1);
  vlt_timing_top uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .hsync_n_i(hpin), .hsync_n_o(hsync_n_o),
    .hsync_n_oe(hsync_n_oe), .vsync_n_i(vpin), .vsync_n_o(vsync_n_o), .vsync_n_oe(vsync_n_oe),
    .composite_sync_n(composite_sync_n), .composite_blank(composite_blank),
    .frame_flyback_flag(frame_flyback_flag), .memory_bus_request(memory_bus_request),
    .vram_transfer_strobe(vram_transfer_strobe), .pixel_shift_clock_n(pixel_shift_clock_n));
  vlt_sync_source #(.LINE(120), .LINES(17), .PULSE(4)) src (.hclk(hclk), .hresetn(hresetn),
    .en(sl_en), .hsync_n(src_h), .vsync_n(src_v));

  // --------------------------------
  // Reporting and timeout
  // --------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Ceiling well above the roughly 20000 cycles the sequence needs
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fail_count++;
      report_and_stop;
    end
  end

  // --------------------------------
  // Bus and measurement tasks
  // --------------------------------
  // One single AHB-Lite transfer; waits on hready only, the timeout bounds it
  task automatic ahb(input logic wr, input logic [IW-1:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {20'h00000, idx, 2'b00};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [IW-1:0] idx, input logic [31:0] exp);
    ahb(1'b0, idx, 32'h00000000);
    check(rd, exp, "register read");
  endtask
  function automatic logic sg(input int i);
    case (i)
      0: sg = pixel_shift_clock_n;
      1: sg = composite_blank;
      2: sg = hsync_n_o;
      3: sg = frame_flyback_flag;
      4: sg = memory_bus_request;
      5: sg = vram_transfer_strobe;
      6: sg = composite_sync_n;
      default: sg = vsync_n_o;
    endcase
  endfunction
  task automatic upto(input int i, input logic v);
    while (sg(i) !== v) @(posedge hclk);
  endtask
  // Counts cycles while signal i holds level v; c counts cycles with sync high, for serration
  task automatic hold(input int i, input logic v, inout int k, inout int c);
    while (sg(i) === v)
    begin
      c += (composite_sync_n === 1'b1);
      @(posedge hclk);
      k++;
    end
  endtask
  // Length of the next full run of level v
  task automatic run(input int i, input logic v, output int k);
    int c;
    c = 0;
    upto(i, !v);
    upto(i, v);
    k = 0;
    hold(i, v, k, c);
  endtask
  // Edge-to-edge period of level v
  task automatic per(input int i, input logic v, output int k);
    int c;
    c = 0;
    upto(i, !v);
    upto(i, v);
    k = 0;
    hold(i, v, k, c);
    hold(i, !v, k, c);
  endtask
  task automatic offset(output int k);
    upto(0, 1'b1);
    upto(0, 1'b0);
    k = 0;
    while (composite_blank !== 1'b0 && k < 30)
    begin
      @(posedge hclk);
      k++;
    end
  endtask

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial
  begin
    int c;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(composite_blank, 1'b1, "blank after reset");
    check(pixel_shift_clock_n, 1'b1, "shift clock after reset");
    for (int i = 0; i < 9; i++)
      rchk(TIDX[i], i == 7 ? RST_VDISPLAY : (i == 8 ? RST_LINE_TIME : RST_SEG));
    rchk(IDX_CTRL, RST_CTRL);
    rchk(10'h030, 32'h00000000);
    for (int i = 0; i < 9; i++)
      ahb(1'b1, TIDX[i], TVAL[i]);
    for (int i = 0; i < 9; i++)
      rchk(TIDX[i], TVAL[i]);
    // Enable: frame sync must start at once
    ahb(1'b1, IDX_CTRL, 32'h00000001);
    n = 0;
    while (vsync_n_o !== 1'b0 && n < 20)
    begin
      @(posedge hclk);
      n++;
    end
    check(n < 10, 1'b1, "frame sync start");
    check(hsync_n_oe, 1'b1, "master drives sync");
    // Timing registers are locked while running
    ahb(1'b1, IDX_DISPLAY, 32'h0000004D);
    rchk(IDX_DISPLAY, TVAL[2]);
    // Line segments of displayed lines
    upto(3, 1'b0);
    run(0, 1'b0, n);
    check(n, 40, "shift clock run");
    run(1, 1'b0, n);
    check(n, 40, "unblanked run");
    run(2, 1'b0, n);
    check(n, 6, "line sync width");
    per(0, 1'b0, n);
    check(n, 100, "line period");
    run(4, 1'b1, n);
    check(n, 20, "bus request width");
    run(5, 1'b1, n);
    check(n, 1, "transfer strobe width");
    offset(off0);
    // Frame flyback and frame period, in half lines of 50 units
    run(3, 1'b1, n);
    check(n, 700, "flyback length");
    per(3, 1'b1, n);
    check(n, 1800, "frame period");
    upto(3, 1'b1);
    repeat (10) @(posedge hclk);
    n = 0;
    c = 0;
    repeat (680)
    begin
      @(posedge hclk);
      n += (composite_blank !== 1'b1);
    end
    check(n, 0, "blank through flyback");
    // Plain versus serrated frame sync
    for (int s = 1; s >= 0; s--)
    begin
      ahb(1'b1, IDX_CTRL, 32'h00000001 | (s << CTRL_STANDARD));
      run(7, 1'b0, n);
      c = 0;
      n = 0;
      upto(7, 1'b1);
      upto(7, 1'b0);
      hold(7, 1'b0, n, c);
      check(c == 0, s, "plain frame sync");
    end
    // Interlace: every other field carries one extra half line of blanking
    ahb(1'b1, IDX_CTRL, 32'h00000001 | (1 << CTRL_INTERLACE));
    run(3, 1'b1, n);
    run(3, 1'b1, c);
    check(n + c, 1450, "two field flybacks");
    // Extra output delay of five cycles
    ahb(1'b1, IDX_CTRL, 32'h00000001 | (5 << CTRL_DLY_LO));
    per(0, 1'b0, n);
    offset(n);
    check(n, off0 + 5, "sync and blank delay");
    run(2, 1'b0, n);
    check(n, 6, "delayed line sync width");
    // Force blank wins over blanking off; blanking off opens flyback
    ahb(1'b1, IDX_CTRL, 32'h00000001 | (3 << CTRL_FORCE_BLANK));
    upto(1, 1'b1);
    n = 0;
    repeat (200)
    begin
      @(posedge hclk);
      n += (composite_blank !== 1'b1);
    end
    check(n, 0, "forced blank");
    ahb(1'b1, IDX_CTRL, 32'h00000001 | (1 << CTRL_BLANK_OFF));
    upto(3, 1'b1);
    repeat (5) @(posedge hclk);
    check(composite_blank, 1'b0, "blanking turned off");
    // Disabled: blank held, shift clock stopped
    ahb(1'b1, IDX_CTRL, 32'h00000000);
    repeat (20) @(posedge hclk);
    n = 0;
    repeat (300)
    begin
      @(posedge hclk);
      n += (composite_blank !== 1'b1) + (pixel_shift_clock_n !== 1'b1);
    end
    check(n, 0, "disabled outputs");
    // Slave mode: line period follows the external source
    ahb(1'b1, IDX_CTRL, 32'h00000001 | (1 << CTRL_SLAVE));
    sl_en <= 1'b1;
    @(posedge hclk);
    check(hsync_n_oe, 1'b0, "slave releases sync");
    check(vsync_n_oe, 1'b0, "slave releases frame sync");
    upto(3, 1'b0);
    per(0, 1'b0, n);
    per(0, 1'b0, n);
    check(n, 120, "slave line period");
    report_and_stop;
  end
endmodule
